// ### hdl/rfw_pkg.sv
// constants, register map and field layout of the reflective window gating block
package rfw_pkg;
  // datapath widths
  localparam int ADDR_W    = 26;  // memory physical address bits 28:3
  localparam int CADDR_W   = 37;  // cluster link address bits 39:3
  localparam int DATA_W    = 64;
  localparam int SEL_W     = 8;
  localparam int OFS_W     = 9;   // in-page offset bits 11:3
  localparam int TXPG_W    = 28;  // cluster page bits 39:12
  localparam int RXPG_W    = 17;  // physical page bits 28:12
  localparam int WIN_N     = 16;
  localparam int WIN_W     = 4;
  localparam int SEG_LSB   = 33;  // segment index is cluster bits 39:36
  localparam int NODE_W    = 4;
  localparam int SUB_W     = 4;
  // transmit fifo depth per board variant
  localparam int TXF_DEPTH_SMALL = 449;
  localparam int TXF_DEPTH_LARGE = 450;
  localparam int TXF_PTR_W       = 9;
  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_SENSE    = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_CLR  = 8'h0c;
  localparam logic [7:0] REG_INT_EN   = 8'h10;
  localparam logic [7:0] REG_TXW_IDX  = 8'h14;
  localparam logic [7:0] REG_TXW_DATA = 8'h18;
  localparam logic [7:0] REG_RXS_IDX  = 8'h1c;
  localparam logic [7:0] REG_RXS_DATA = 8'h20;
  localparam logic [7:0] REG_RXP_IDX  = 8'h24;
  localparam logic [7:0] REG_RXP_DATA = 8'h28;
  localparam logic [7:0] REG_RX_SRC   = 8'h2c;
  localparam logic [7:0] REG_RX_ADDR  = 8'h30;
  // control register bits
  localparam int CTRL_ONLINE = 0;
  localparam int CTRL_LOOP   = 1;
  localparam int CTRL_TXEN   = 2;
  localparam int CTRL_W      = 3;
  // sense register bits
  localparam int SNS_ONLINE  = 0;
  localparam int SNS_FULL    = 1;
  localparam int SNS_EMPTY   = 2;
  localparam int SNS_VME     = 3;
  localparam int SNS_CNT_LSB = 16;
  // interrupt status bits
  localparam int INT_RX_DONE = 0;
  localparam int INT_RX_DROP = 1;
  localparam int INT_TX_FULL = 2;
  localparam int INT_TX_SHUT = 3;
  localparam int INT_W       = 4;
  // transmit window control field, bits 3-0
  localparam int TXC_W    = 4;
  localparam int TXC_OPEN = 3;
  // receive page entry: bit 0 open, page above it
  localparam int RXP_OPEN = 0;
  localparam int RXS_OPEN = 0;
  localparam int SRC_SUB_LSB = 4;
  // receive state machine
  typedef enum logic [1:0] {RFW_IDLE, RFW_READ, RFW_WRITE} rfw_rx_type;
endpackage

// ### hdl/rfw_txfifo.sv
// transmit fifo held in flip-flops, in-order delivery
`timescale 1ns/1ps
module rfw_txfifo
  import rfw_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = TXF_DEPTH_LARGE
) (
  input  wire logic                 mclk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 push_in,
  input  wire logic [WIDTH-1:0]     push_data_in,
  input  wire logic                 pop_in,
  output logic      [WIDTH-1:0]     head_out,
  output logic                      full_out,
  output logic                      empty_out,
  output logic      [TXF_PTR_W:0]   count_out
);
  localparam logic [TXF_PTR_W-1:0] LAST = TXF_PTR_W'(DEPTH - 1);
  localparam logic [TXF_PTR_W:0]   FULL = (TXF_PTR_W + 1)'(DEPTH);

  logic [WIDTH-1:0]     mem [DEPTH];
  logic [TXF_PTR_W-1:0] wr_ptr;
  logic [TXF_PTR_W-1:0] rd_ptr;
  logic [TXF_PTR_W:0]   count;
  wire                  do_push = push_in && (count != FULL);
  wire                  do_pop  = pop_in && (count != '0);

  assign full_out  = (count == FULL);
  assign empty_out = (count == '0);
  assign count_out = count;
  assign head_out  = mem[rd_ptr];

  // storage has no reset; only valid slots are ever read
  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  // pointers wrap at the real depth, not a power of two
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{TXF_PTR_W{1'b0}}, do_push} - {{TXF_PTR_W{1'b0}}, do_pop};
    end
  end
endmodule // rfw_txfifo

// ### hdl/rfw_gating.sv
// reflective adapter window gating, address translation and receive write path
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module rfw_gating
  import rfw_pkg::*;
#(
  parameter bit              LARGE_FIFO = 1'b1,
  parameter logic [NODE_W-1:0] NODE_ID  = 4'h0  // value arbitrary
) (
  input  wire logic                 mclk_in,
  input  wire logic                 nrst_in,
  // classic wishbone slave
  input  wire logic                 wb_cyc_in,
  input  wire logic                 wb_stb_in,
  input  wire logic                 wb_we_in,
  input  wire logic [7:0]           wb_adr_in,
  input  wire logic [31:0]          wb_dat_in,
  input  wire logic [3:0]           wb_sel_in,
  output logic      [31:0]          wb_dat_out,
  output logic                      wb_ack_out,
  output logic                      irq_out,
  // snooped host writes (local host bus or vme port)
  input  wire logic                 snoop_valid_in,
  input  wire logic                 snoop_vme_in,
  input  wire logic [ADDR_W-1:0]    snoop_addr_in,
  input  wire logic [DATA_W-1:0]    snoop_data_in,
  input  wire logic [SEL_W-1:0]     snoop_sel_in,
  output logic                      stall_out,
  // cluster link bus transmit side
  output logic                      link_tx_valid_out,
  input  wire logic                 link_tx_ready_in,
  output logic      [CADDR_W-1:0]   link_tx_addr_out,
  output logic      [DATA_W-1:0]    link_tx_data_out,
  output logic      [SEL_W-1:0]     link_tx_sel_out,
  // cluster link bus receive side
  input  wire logic                 link_rx_valid_in,
  output logic                      link_rx_ready_out,
  input  wire logic [CADDR_W-1:0]   link_rx_addr_in,
  input  wire logic [DATA_W-1:0]    link_rx_data_in,
  input  wire logic [SEL_W-1:0]     link_rx_sel_in,
  input  wire logic [NODE_W-1:0]    link_rx_node_in,
  input  wire logic [SUB_W-1:0]     link_rx_sub_in,
  // local buffer memory port, reads for byte merges and writes
  output logic                      mem_req_out,
  output logic                      mem_we_out,
  output logic      [ADDR_W-1:0]    mem_addr_out,
  output logic      [DATA_W-1:0]    mem_wdata_out,
  output logic      [SEL_W-1:0]     mem_sel_out,
  input  wire logic                 mem_ack_in,
  input  wire logic [DATA_W-1:0]    mem_rdata_in
);
  localparam int ENT_W = CADDR_W + DATA_W + SEL_W;

  // window index of a memory physical address (address bits 15:12)
  function automatic logic [WIN_W-1:0] page_index(input logic [ADDR_W-1:0] a);
    page_index = a[OFS_W +: WIN_W];
  endfunction

  // byte mask from lane selects
  function automatic logic [DATA_W-1:0] lane_mask(input logic [SEL_W-1:0] s);
    for (int i = 0; i < SEL_W; i++) begin
      lane_mask[i*8 +: 8] = {8{s[i]}};
    end
  endfunction

  // software state
  logic [CTRL_W-1:0]             ctrl;
  logic [INT_W-1:0]              int_stat;
  logic [INT_W-1:0]              int_en;
  logic [WIN_W-1:0]              txw_idx;
  logic [WIN_W-1:0]              rxs_idx;
  logic [WIN_W-1:0]              rxp_idx;
  logic [TXC_W-1:0]              txw_ctrl [WIN_N];
  logic [TXPG_W-1:0]             txw_page [WIN_N];
  logic                          rxs_open [WIN_N];
  logic                          rxp_open [WIN_N];
  logic [RXPG_W-1:0]             rxp_page [WIN_N];
  logic [NODE_W+SUB_W-1:0]       rx_src;
  logic [ADDR_W-1:0]             rx_addr;
  logic                          last_vme;
  // receive state
  rfw_rx_type                    rx_state;
  logic [DATA_W-1:0]             rx_data;
  logic [SEL_W-1:0]              rx_sel;

  // bus decode
  wire        wb_req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire        wb_wr    = wb_req && wb_we_in && (wb_sel_in == 4'hf);
  wire        wr_ctrl  = wb_wr && (wb_adr_in == REG_CTRL);
  wire        wr_clr   = wb_wr && (wb_adr_in == REG_INT_CLR);
  wire        wr_en    = wb_wr && (wb_adr_in == REG_INT_EN);
  wire        wr_txi   = wb_wr && (wb_adr_in == REG_TXW_IDX);
  wire        wr_txd   = wb_wr && (wb_adr_in == REG_TXW_DATA);
  wire        wr_rsi   = wb_wr && (wb_adr_in == REG_RXS_IDX);
  wire        wr_rsd   = wb_wr && (wb_adr_in == REG_RXS_DATA);
  wire        wr_rpi   = wb_wr && (wb_adr_in == REG_RXP_IDX);
  wire        wr_rpd   = wb_wr && (wb_adr_in == REG_RXP_DATA);
  wire        wr_src   = wb_wr && (wb_adr_in == REG_RX_SRC);
  wire        wr_addr  = wb_wr && (wb_adr_in == REG_RX_ADDR);
  wire        online   = ctrl[CTRL_ONLINE];
  wire        loopback = ctrl[CTRL_LOOP];
  wire        tx_en    = ctrl[CTRL_TXEN];

  // transmit gating and translation
  wire [WIN_W-1:0]   snp_win   = page_index(snoop_addr_in);
  wire               snp_open  = txw_ctrl[snp_win][TXC_OPEN];
  wire               fifo_full;
  wire               fifo_empty;
  wire [TXF_PTR_W:0] fifo_count;
  wire [ENT_W-1:0]   fifo_head;
  wire               snp_take  = snoop_valid_in && online && snp_open && !fifo_full;
  wire               snp_shut  = snoop_valid_in && online && !snp_open;
  wire [CADDR_W-1:0] snp_caddr = {txw_page[snp_win], snoop_addr_in[OFS_W-1:0]};
  wire [ENT_W-1:0]   snp_ent   = {snp_caddr, snoop_data_in, snoop_sel_in};

  // stall while full so the host's write waits in the post buffer
  assign stall_out = fifo_full;

  // fifo head routing: link, or our own receiver in loopback
  wire [CADDR_W-1:0] head_addr = fifo_head[ENT_W-1 -: CADDR_W];
  wire [DATA_W-1:0]  head_data = fifo_head[SEL_W +: DATA_W];
  wire [SEL_W-1:0]   head_sel  = fifo_head[SEL_W-1:0];
  wire               tx_go     = online && tx_en && !fifo_empty;
  wire               rx_idle   = (rx_state == RFW_IDLE);
  wire               fifo_pop  = tx_go && (loopback ? rx_idle : link_tx_ready_in);

  assign link_tx_valid_out = tx_go && !loopback;
  assign link_tx_addr_out  = head_addr;
  assign link_tx_data_out  = head_data;
  assign link_tx_sel_out   = head_sel;
  assign link_rx_ready_out = rx_idle && !loopback;

  // receive source select and window checks
  wire               rx_valid = loopback ? tx_go : link_rx_valid_in;
  wire [CADDR_W-1:0] rx_caddr = loopback ? head_addr : link_rx_addr_in;
  wire [DATA_W-1:0]  rx_din   = loopback ? head_data : link_rx_data_in;
  wire [SEL_W-1:0]   rx_sin   = loopback ? head_sel : link_rx_sel_in;
  wire [NODE_W-1:0]  rx_node  = loopback ? NODE_ID : link_rx_node_in;
  wire [SUB_W-1:0]   rx_sub   = loopback ? SUB_W'(0) : link_rx_sub_in;
  wire [WIN_W-1:0]   rx_seg   = rx_caddr[SEG_LSB +: WIN_W];
  wire [WIN_W-1:0]   rx_pgi   = rx_caddr[OFS_W +: WIN_W];
  wire               rx_pass  = rxs_open[rx_seg] && rxp_open[rx_pgi];
  wire [ADDR_W-1:0]  rx_phys  = {rxp_page[rx_pgi], rx_caddr[OFS_W-1:0]};
  wire               rx_take  = rx_valid && rx_idle;
  wire               rx_byte  = $onehot(rx_sin);
  wire               rx_done  = (rx_state == RFW_WRITE) && mem_ack_in;
  wire [DATA_W-1:0]  rmw_mask = lane_mask(rx_sel);
  wire [DATA_W-1:0]  rmw_data = (mem_rdata_in & ~rmw_mask) | (rx_data & rmw_mask);

  // interrupt events
  wire [INT_W-1:0] ev;
  assign ev[INT_RX_DONE] = rx_done;
  assign ev[INT_RX_DROP] = rx_take && !rx_pass;
  assign ev[INT_TX_FULL] = snoop_valid_in && online && snp_open && fifo_full;
  assign ev[INT_TX_SHUT] = snp_shut;
  assign irq_out         = |(int_stat & int_en);

  // read mux
  wire [31:0] sense_w = {6'h00, fifo_count, 12'h000, last_vme, fifo_empty, fifo_full, online};
  logic [31:0] rd_w;
  always_comb begin
    case (wb_adr_in)
      REG_CTRL:     rd_w = {29'h0000000, ctrl};
      REG_SENSE:    rd_w = sense_w;
      REG_INT_STAT: rd_w = {28'h0000000, int_stat};
      REG_INT_EN:   rd_w = {28'h0000000, int_en};
      REG_TXW_IDX:  rd_w = {28'h0000000, txw_idx};
      REG_TXW_DATA: rd_w = {txw_page[txw_idx], txw_ctrl[txw_idx]};
      REG_RXS_IDX:  rd_w = {28'h0000000, rxs_idx};
      REG_RXS_DATA: rd_w = {31'h00000000, rxs_open[rxs_idx]};
      REG_RXP_IDX:  rd_w = {28'h0000000, rxp_idx};
      REG_RXP_DATA: rd_w = {14'h0000, rxp_page[rxp_idx], rxp_open[rxp_idx]};
      REG_RX_SRC:   rd_w = {24'h000000, rx_src};
      REG_RX_ADDR:  rd_w = {6'h00, rx_addr};
      default:      rd_w = 32'h00000000;
    endcase
  end

  // bus answer: ack one cycle after the request, unmapped reads zero
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= wb_req;
      wb_dat_out <= wb_req ? rd_w : wb_dat_out;
    end
  end

  // control, interrupt and index registers; a new event beats a clear
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl     <= '0;
      int_stat <= '0;
      int_en   <= '0;
      txw_idx  <= '0;
      rxs_idx  <= '0;
      rxp_idx  <= '0;
      last_vme <= 1'b0;
    end else begin
      ctrl     <= wr_ctrl ? wb_dat_in[CTRL_W-1:0] : ctrl;
      int_stat <= (int_stat & ~(wr_clr ? wb_dat_in[INT_W-1:0] : '0)) | ev;
      int_en   <= wr_en ? wb_dat_in[INT_W-1:0] : int_en;
      txw_idx  <= wr_txi ? wb_dat_in[WIN_W-1:0] : txw_idx;
      rxs_idx  <= wr_rsi ? wb_dat_in[WIN_W-1:0] : rxs_idx;
      rxp_idx  <= wr_rpi ? wb_dat_in[WIN_W-1:0] : rxp_idx;
      last_vme <= snp_take ? snoop_vme_in : last_vme;
    end
  end

  // window tables, one independent entry per window, all closed at reset
  for (genvar w = 0; w < WIN_N; w++) begin : g_win
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        txw_ctrl[w] <= '0;
        txw_page[w] <= '0;
        rxs_open[w] <= 1'b0;
        rxp_open[w] <= 1'b0;
        rxp_page[w] <= '0;
      end else begin
        if (wr_txd && txw_idx == WIN_W'(w)) begin
          txw_ctrl[w] <= wb_dat_in[TXC_W-1:0];
          txw_page[w] <= wb_dat_in[TXC_W +: TXPG_W];
        end
        if (wr_rsd && rxs_idx == WIN_W'(w)) begin
          rxs_open[w] <= wb_dat_in[RXS_OPEN];
        end
        if (wr_rpd && rxp_idx == WIN_W'(w)) begin
          rxp_open[w] <= wb_dat_in[RXP_OPEN];
          rxp_page[w] <= wb_dat_in[RXP_OPEN + 1 +: RXPG_W];
        end
      end
    end
  end

  // captured source and address; a new capture wins over a software write
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_src  <= '0;
      rx_addr <= '0;
    end else if (rx_take && rx_pass) begin
      rx_src  <= {rx_sub, rx_node};
      rx_addr <= rx_phys;
    end else begin
      rx_src  <= wr_src ? wb_dat_in[NODE_W+SUB_W-1:0] : rx_src;
      rx_addr <= wr_addr ? wb_dat_in[ADDR_W-1:0] : rx_addr;
    end
  end

  // receive write: single bytes read first, merge, then write the word
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_state      <= RFW_IDLE;
      rx_data       <= '0;
      rx_sel        <= '0;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= '0;
      mem_wdata_out <= '0;
      mem_sel_out   <= '0;
    end else begin
      case (rx_state)
        RFW_IDLE: begin
          if (rx_take && rx_pass) begin
            rx_data       <= rx_din;
            rx_sel        <= rx_sin;
            mem_addr_out  <= rx_phys;
            mem_wdata_out <= rx_din;
            mem_sel_out   <= rx_sin;
            mem_req_out   <= 1'b1;
            mem_we_out    <= !rx_byte;
            rx_state      <= rx_byte ? RFW_READ : RFW_WRITE;
          end
        end
        RFW_READ: begin
          if (mem_ack_in) begin
            mem_wdata_out <= rmw_data;
            mem_sel_out   <= '1;
            mem_we_out    <= 1'b1;
            rx_state      <= RFW_WRITE;
          end
        end
        RFW_WRITE: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            mem_we_out  <= 1'b0;
            rx_state    <= RFW_IDLE;
          end
        end
        default: begin
          mem_req_out <= 1'b0;
          rx_state    <= RFW_IDLE;
        end
      endcase
    end
  end

  // transmit fifo, depth set by board variant
  rfw_txfifo #(
    .WIDTH (ENT_W),
    .DEPTH (LARGE_FIFO ? TXF_DEPTH_LARGE : TXF_DEPTH_SMALL)
  ) u_txfifo (
    .mclk_in      (mclk_in),
    .nrst_in      (nrst_in),
    .push_in      (snp_take),
    .push_data_in (snp_ent),
    .pop_in       (fifo_pop),
    .head_out     (fifo_head),
    .full_out     (fifo_full),
    .empty_out    (fifo_empty),
    .count_out    (fifo_count)
  );
endmodule // rfw_gating

// ### tb/rfw_gating_monitor.sv
// port checker for the reflective window gating block
`timescale 1ns/1ps
module rfw_gating_monitor
  import rfw_pkg::*;
(
  input wire logic               mclk_in,
  input wire logic               nrst_in,
  input wire logic               wb_cyc_in,
  input wire logic               wb_stb_in,
  input wire logic               wb_ack_out,
  input wire logic               link_tx_valid_out,
  input wire logic               link_tx_ready_in,
  input wire logic [CADDR_W-1:0] link_tx_addr_out,
  input wire logic [DATA_W-1:0]  link_tx_data_out,
  input wire logic               link_rx_ready_out,
  input wire logic               mem_req_out,
  input wire logic               mem_we_out,
  input wire logic [ADDR_W-1:0]  mem_addr_out,
  input wire logic [SEL_W-1:0]   mem_sel_out,
  input wire logic               mem_ack_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // read phase of a byte merge, then the merged full-word write
  sequence s_rd_ack;
    mem_req_out && !mem_we_out && mem_ack_in;
  endsequence
  sequence s_merge;
    mem_req_out && mem_we_out && mem_sel_out == 8'hff && $stable(mem_addr_out);
  endsequence
  AST_ACK_ONE: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("register ack late");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("register ack too long");
  AST_TX_HOLD: assert property (link_tx_valid_out && !link_tx_ready_in |=>
    link_tx_valid_out && $stable(link_tx_addr_out) && $stable(link_tx_data_out))
    else $error("link entry changed while stalled");
  AST_RX_BUSY: assert property (mem_req_out |-> !link_rx_ready_out)
    else $error("receiver ready while busy");
  AST_MEM_HOLD: assert property (mem_req_out && !mem_ack_in |=>
    mem_req_out && $stable(mem_addr_out))
    else $error("memory request dropped or moved");
  AST_BYTE_RMW: assert property (s_rd_ack |=> s_merge)
    else $error("no merged write after read");
  AST_MEM_DROP: assert property (mem_req_out && mem_we_out && mem_ack_in |=> !mem_req_out)
    else $error("memory request held after write");
  AST_DIRECT: assert property ($rose(mem_req_out) && mem_we_out |-> !$onehot(mem_sel_out))
    else $error("single byte written directly");
endmodule // rfw_gating_monitor

bind rfw_gating rfw_gating_monitor rfw_gating_monitor_i (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .link_tx_valid_out(link_tx_valid_out),
  .link_tx_ready_in(link_tx_ready_in), .link_tx_addr_out(link_tx_addr_out),
  .link_tx_data_out(link_tx_data_out), .link_rx_ready_out(link_rx_ready_out),
  .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
  .mem_sel_out(mem_sel_out), .mem_ack_in(mem_ack_in));

// ### tb/rfw_far_node.sv
// far cluster node: takes each link transfer and echoes it back to the receiver
`timescale 1ns/1ps
module rfw_far_node
  import rfw_pkg::*;
(
  input  wire logic               mclk_in,
  input  wire logic               nrst_in,
  input  wire logic               tx_valid_in,
  output logic                    tx_ready_out,
  input  wire logic [CADDR_W-1:0] tx_addr_in,
  input  wire logic [DATA_W-1:0]  tx_data_in,
  input  wire logic [SEL_W-1:0]   tx_sel_in,
  output logic                    rx_valid_out,
  input  wire logic               rx_ready_in,
  output logic      [CADDR_W-1:0] rx_addr_out,
  output logic      [DATA_W-1:0]  rx_data_out,
  output logic      [SEL_W-1:0]   rx_sel_out,
  output logic      [NODE_W-1:0]  rx_node_out,
  output logic      [SUB_W-1:0]   rx_sub_out
);
  logic               full;
  logic [CADDR_W-1:0] a;
  logic [DATA_W-1:0]  d;
  logic [SEL_W-1:0]   s;
  // one slot: the sender stalls while the echo waits, so ready really drops
  assign tx_ready_out = !full;
  assign rx_valid_out = full;
  // idle lines show the inverse so stale data never looks valid
  assign rx_addr_out = full ? a : ~a;
  assign rx_data_out = full ? d : ~d;
  assign rx_sel_out  = full ? s : ~s;
  assign rx_node_out = 4'h5;
  assign rx_sub_out  = 4'h2;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      full <= 1'b0;
      {a, d, s} <= '0;
    end else if (!full && tx_valid_in) begin
      full <= 1'b1;
      {a, d, s} <= {tx_addr_in, tx_data_in, tx_sel_in};
    end else if (full && rx_ready_in) begin
      full <= 1'b0;
    end
  end
endmodule // rfw_far_node

// ### tb/testbench.sv
// self-checking bench for the reflective window gating block
`timescale 1ns/1ps
module testbench;
  import rfw_pkg::*;
  localparam logic [27:0] TXPG = 28'h0000001;
  localparam logic [16:0] RXPG = 17'h0abcd;
  logic mclk_in = 1'b0, nrst_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic sv = 1'b0, vme = 1'b0, ack_m = 1'b0, pend = 1'b0;
  logic [7:0] adr = 8'h00, ssel = 8'h00;
  logic [31:0] dat = 32'h0, rd, wb_dat;
  logic [ADDR_W-1:0] saddr = '0, last_a, maddr;
  logic [63:0] sdata = '0, rdata = '0, last_d, td, rdd, mwd;
  logic [CADDR_W-1:0] ta, ra;
  logic [7:0] ts, rs, msel;
  logic [3:0] rn, rsb;
  logic wb_ack, irq, stall, tv, tr, rv, rrdy, mreq, mwe;
  int err_total = 0, num_checks = 0, ncyc = 0, ntx = 0, nwr = 0;
  logic [63:0] mem [logic [ADDR_W-1:0]];
  rfw_gating #(.LARGE_FIFO(1'b1), .NODE_ID(4'h0)) rfw_gating_i (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(4'hf), .wb_dat_out(wb_dat),
    .wb_ack_out(wb_ack), .irq_out(irq), .snoop_valid_in(sv), .snoop_vme_in(vme),
    .snoop_addr_in(saddr), .snoop_data_in(sdata), .snoop_sel_in(ssel), .stall_out(stall),
    .link_tx_valid_out(tv), .link_tx_ready_in(tr), .link_tx_addr_out(ta),
    .link_tx_data_out(td), .link_tx_sel_out(ts), .link_rx_valid_in(rv),
    .link_rx_ready_out(rrdy), .link_rx_addr_in(ra), .link_rx_data_in(rdd),
    .link_rx_sel_in(rs), .link_rx_node_in(rn), .link_rx_sub_in(rsb), .mem_req_out(mreq),
    .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_sel_out(msel),
    .mem_ack_in(ack_m), .mem_rdata_in(rdata));
  rfw_far_node rfw_far_node_i (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .tx_valid_in(tv), .tx_ready_out(tr),
    .tx_addr_in(ta), .tx_data_in(td), .tx_sel_in(ts), .rx_valid_out(rv),
    .rx_ready_in(rrdy), .rx_addr_out(ra), .rx_data_out(rdd), .rx_sel_out(rs),
    .rx_node_out(rn), .rx_sub_out(rsb));
  always #2.5 mclk_in = ~mclk_in;
  // memory answers each phase two cycles after the request, so request hold is exercised
  always @(posedge mclk_in) begin
    if (ack_m) ack_m <= 1'b0;
    else if (pend) begin
      logic [63:0] m;
      m = mem.exists(maddr) ? mem[maddr] : 64'h0;
      ack_m <= 1'b1;
      pend <= 1'b0;
      rdata <= m;
      if (mwe) begin
        for (int b = 0; b < 8; b++) if (msel[b]) m[8*b+:8] = mwd[8*b+:8];
        mem[maddr] = m;
        last_a <= maddr;
        last_d <= m;
        nwr++;
      end
    end else if (mreq) pend <= 1'b1;
  end
  // every accepted link entry must match the capture order and translation
  always @(posedge mclk_in) if (tv === 1'b1 && tr === 1'b1) begin
    chk({27'h0, ta}, {27'h0, TXPG, ntx[8:0]});
    chk(td, 64'(ntx));
    chk({56'h0, ts}, 64'hff);
    ntx++;
  end
  always @(posedge mclk_in) begin
    ncyc++;
    if (ncyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n == 20) err_total++;
    rd = wb_dat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk({32'h0, rd}, {32'h0, e});
  endtask
  task automatic snp(input logic [25:0] a, input logic [63:0] d, input logic [7:0] s,
                     input logic v);
    @(posedge mclk_in);
    {sv, vme} <= {1'b1, v};
    saddr <= a;
    sdata <= d;
    ssel <= s;
    @(posedge mclk_in);
    sv <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rr(REG_CTRL, 32'h0);
    rr(REG_SENSE, 32'h4);
    rr(REG_INT_STAT, 32'h0);
    wb(1'b1, REG_INT_EN, 32'hf);
    wb(1'b1, REG_TXW_DATA, {TXPG, 4'hf});
    rr(REG_TXW_DATA, {TXPG, 4'hf});
    wb(1'b1, REG_CTRL, 32'h1);
    snp(26'h200, 64'h0, 8'hff, 1'b0);
    rr(REG_INT_STAT, 32'h8);
    chk({63'h0, irq}, 64'h1);
    wb(1'b1, REG_INT_CLR, 32'hf);
    rr(REG_INT_STAT, 32'h0);
    chk({63'h0, irq}, 64'h0);
    for (int i = 0; i < 449; i++) snp(26'(i), 64'(i), 8'hff, i[0]);
    rr(REG_SENSE, 32'h01c10001);
    chk({63'h0, stall}, 64'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    snp(26'd449, 64'h0, 8'hff, 1'b1);
    rr(REG_SENSE, 32'h01c10000);
    rr(REG_INT_STAT, 32'h0);
    wb(1'b1, REG_CTRL, 32'h1);
    snp(26'd449, 64'd449, 8'hff, 1'b1);
    rr(REG_SENSE, 32'h01c2000b);
    chk({63'h0, stall}, 64'h1);
    wb(1'b1, REG_INT_EN, 32'hb);
    snp(26'h1ff, 64'h0, 8'hff, 1'b0);
    rr(REG_INT_STAT, 32'h4);
    chk({63'h0, irq}, 64'h0);
    wb(1'b1, REG_CTRL, 32'h5);
    repeat (3000) if (ntx < 450) @(posedge mclk_in);
    chk(64'(ntx), 64'd450);
    rr(REG_SENSE, 32'hd);
    wb(1'b1, REG_RXS_DATA, 32'h1);
    wb(1'b1, REG_RXP_IDX, 32'h1);
    wb(1'b1, REG_RXP_DATA, {14'h0, RXPG, 1'b1});
    wb(1'b1, REG_RX_SRC, 32'ha5);
    rr(REG_RX_SRC, 32'ha5);
    wb(1'b1, REG_INT_CLR, 32'hf);
    wb(1'b1, REG_CTRL, 32'h7);
    snp(26'h10, 64'h1122334455667788, 8'hff, 1'b0);
    repeat (100) if (nwr < 1) @(posedge mclk_in);
    chk({38'h0, last_a}, {38'h0, RXPG, 9'h10});
    chk(last_d, 64'h1122334455667788);
    rr(REG_RX_ADDR, {6'h0, RXPG, 9'h10});
    wb(1'b0, REG_RX_SRC, 32'h0);
    chk({56'h0, rd[7:0]}, 64'h0);
    snp(26'h10, 64'h0000000000aa0000, 8'h04, 1'b1);
    repeat (100) if (nwr < 2) @(posedge mclk_in);
    chk(last_d, 64'h1122334455aa7788);
    rr(REG_INT_STAT, 32'h1);
    wb(1'b1, REG_RXP_DATA, 32'h0);
    snp(26'h18, 64'h5, 8'hff, 1'b0);
    repeat (20) @(posedge mclk_in);
    chk(64'(nwr), 64'd2);
    rr(REG_INT_STAT, 32'h3);
    chk(64'(ntx), 64'd450);
    // mid-run reset while online in loopback with status pending
    @(posedge mclk_in) nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rr(REG_CTRL, 32'h0);
    rr(REG_INT_STAT, 32'h0);
    test_done();
  end
endmodule // testbench
